// [design/flash_ctrl_pkg.sv]
`default_nettype none
package flash_ctrl_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] REG_CURRENT = 8'h02;
  localparam logic [7:0] REG_CONTROL = 8'h03;
  localparam logic [7:0] REG_FAULT   = 8'h04;
  localparam logic [7:0] REG_UNLOCK  = 8'h80;

  // ==========================================================
  // Reset values and special codes
  localparam logic [7:0] CURRENT_RESET = 8'hb4;
  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] FAULT_RESET   = 8'h00;
  localparam logic [7:0] UNLOCK_KEY    = 8'ha1;
  localparam logic [7:0] CTRL_ASSIST   = 8'h20;
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  localparam logic [7:0] CURRENT_MAX   = 8'hff;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;

  // ==========================================================
  // Field layout
  localparam int         MODE_LSB  = 4;
  localparam int         MODE_MSB  = 5;
  localparam int         TIMER_MSB = 3;
  localparam int         SHORT_BIT = 6;
  localparam int         OVP_BIT   = 7;
  localparam logic [7:0] MODE_MASK = 8'h30;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_ASSIST   = 2'h2;
  localparam logic [1:0] MODE_FLASH    = 2'h3;

  // ==========================================================
  // Serial link
  localparam logic [6:0] DEV_ADDR = 7'h30;  // Arbitrary bus address
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [3:0] BIT_ONE  = 4'h1;
  localparam logic [3:0] BIT_ZERO = 4'h0;

  // ==========================================================
  // Timing
  localparam int CLK_KHZ       = 200000;
  localparam int FLASH_STEP_MS = 30;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA
  } link_state_e;
endpackage
`default_nettype wire

// [design/flash_ctrl.sv]
`default_nettype none
module flash_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int FLASH_STEP_CYCLES = FLASH_STEP_MS * CLK_KHZ
) (
  // System
  input  wire logic       CLOCK_IN,
  input  wire logic       RST_IN,
  // Serial link
  input  wire logic       SCL_LINK_IN,
  input  wire logic       SDA_IN,
  output var  logic       SDA_OUT,
  output var  logic       SDA_OE_OUT,
  // Analog monitors
  input  wire logic       LED_SHORT_IN,
  input  wire logic       OVERVOLT_IN,
  input  wire logic       COIL_BROKEN_IN,
  // Driver controls
  output var  logic       BOOST_EN_OUT,
  output var  logic [1:0] LED_MODE_OUT,
  output var  logic [7:0] DRIVE_CURRENT_OUT,
  output var  logic       FLASH_ACTIVE_OUT
);

  // ==========================================================
  // Helpers
  function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
    sticky_next = set | (cur & ~clr);
  endfunction

  // ==========================================================
  // Link clock domain: bit capture only
  logic [7:0] rx_shift_q;

  // Bits shift on the link's own edge; the core takes the byte
  // only after seeing the eighth rise, while SCL is still high.
  always_ff @(posedge SCL_LINK_IN) begin
    rx_shift_q <= {rx_shift_q[6:0], SDA_IN};
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] short_sync_q;
  logic [1:0] ovp_sync_q;
  logic [1:0] coil_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      scl_sync_q   <= 2'h3;
      sda_sync_q   <= 2'h3;
      short_sync_q <= 2'h0;
      ovp_sync_q   <= 2'h0;
      coil_sync_q  <= 2'h0;
      scl_prev_q   <= 1'b1;
      sda_prev_q   <= 1'b1;
    end else begin
      scl_sync_q   <= {scl_sync_q[0], SCL_LINK_IN};
      sda_sync_q   <= {sda_sync_q[0], SDA_IN};
      short_sync_q <= {short_sync_q[0], LED_SHORT_IN};
      ovp_sync_q   <= {ovp_sync_q[0], OVERVOLT_IN};
      coil_sync_q  <= {coil_sync_q[0], COIL_BROKEN_IN};
      scl_prev_q   <= scl_sync_q[1];
      sda_prev_q   <= sda_sync_q[1];
    end
  end

  wire scl_s      = scl_sync_q[1];
  wire sda_s      = sda_sync_q[1];
  wire short_s    = short_sync_q[1];
  wire ovp_s      = ovp_sync_q[1];
  wire coil_s     = coil_sync_q[1];
  wire start_det  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire scl_rise   = scl_s & ~scl_prev_q;
  wire scl_fall   = ~scl_s & scl_prev_q;

  // ==========================================================
  // Byte framing
  link_state_e state_q;
  logic [3:0]  bit_q;
  logic        ack_q;
  logic [7:0]  rx_byte_q;
  logic [7:0]  ptr_q;
  logic [7:0]  tx_q;
  logic        sda_oe_q;
  logic        wr_stb_q;
  logic [7:0]  wr_data_q;
  logic        rd_stb_q;
  logic [7:0]  rd_val;

  wire byte_fall  = scl_fall & (bit_q == BIT_ACK) & ~ack_q;
  wire ack_end    = scl_fall & (bit_q == BIT_ACK) & ack_q;
  wire data_fall  = scl_fall & (state_q == ST_RDATA) & ~ack_q &
                    (bit_q != BIT_ZERO) & (bit_q < BIT_ACK);
  wire addr_match = (rx_byte_q[7:1] == DEV_ADDR);

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || stop_det) begin
      state_q   <= ST_IDLE;
      bit_q     <= BIT_ZERO;
      ack_q     <= 1'b0;
      sda_oe_q  <= 1'b0;
      wr_stb_q  <= 1'b0;
      rd_stb_q  <= 1'b0;
      if (RST_IN) begin
        rx_byte_q <= ZERO_BYTE;
        ptr_q     <= ZERO_BYTE;
        tx_q      <= ZERO_BYTE;
        wr_data_q <= ZERO_BYTE;
      end
    end else if (start_det) begin
      state_q  <= ST_ADDR;
      bit_q    <= BIT_ZERO;
      ack_q    <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (scl_rise && !ack_q && bit_q < BIT_ACK) begin
        bit_q <= bit_q + BIT_ONE;
        if (bit_q == BIT_LAST) begin
          rx_byte_q <= rx_shift_q;
        end
      end
      // Master NACK ends a read burst
      if (scl_rise && ack_q && state_q == ST_RDATA && sda_s) begin
        state_q <= ST_IDLE;
      end
      if (byte_fall) begin
        ack_q <= 1'b1;
        case (state_q)
          ST_ADDR: begin
            sda_oe_q <= addr_match;
            if (!addr_match) begin
              state_q <= ST_IDLE;
            end else if (rx_byte_q[0]) begin
              state_q <= ST_RDATA;
            end else begin
              state_q <= ST_REG;
            end
          end
          ST_REG: begin
            sda_oe_q <= 1'b1;
            ptr_q    <= rx_byte_q;
            state_q  <= ST_WDATA;
          end
          ST_WDATA: begin
            sda_oe_q  <= 1'b1;
            wr_stb_q  <= 1'b1;
            wr_data_q <= rx_byte_q;
          end
          default: sda_oe_q <= 1'b0;
        endcase
      end else if (ack_end) begin
        ack_q <= 1'b0;
        bit_q <= BIT_ZERO;
        if (state_q == ST_RDATA) begin
          tx_q     <= {rd_val[6:0], 1'b0};
          sda_oe_q <= ~rd_val[7];
          rd_stb_q <= 1'b1;
        end else begin
          sda_oe_q <= 1'b0;
        end
      end else if (data_fall) begin
        sda_oe_q <= ~tx_q[7];
        tx_q     <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign SDA_OUT    = 1'b0;
  assign SDA_OE_OUT = sda_oe_q;

  // ==========================================================
  // Register file and driver control
  logic [7:0]  current_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  fault_q;
  logic        unlock_q;
  logic        boost_q;
  logic        flash_q;
  logic [3:0]  steps_q;
  logic [31:0] cyc_q;

  wire       wr_cur     = wr_stb_q & (ptr_q == REG_CURRENT);
  wire       wr_ctl     = wr_stb_q & (ptr_q == REG_CONTROL);
  wire       wr_key     = wr_stb_q & (ptr_q == REG_UNLOCK);
  wire       rd_fault   = rd_stb_q & (ptr_q == REG_FAULT);
  wire [1:0] mode       = ctrl_q[MODE_MSB:MODE_LSB];
  wire       operating  = (mode != MODE_SHUTDOWN);
  wire       set_short  = operating & short_s;
  wire       set_ovp    = operating & ovp_s;
  // A broken coil also trips shutdown, so control no longer reads back
  wire       fault_evt  = set_short | set_ovp | (operating & coil_s);
  wire       step_end   = (cyc_q == 32'(FLASH_STEP_CYCLES - 1));
  wire       timer_done = (mode == MODE_FLASH) & step_end & (steps_q == BIT_ZERO);
  wire [7:0] ctrl_wr    = wr_data_q;
  // Expiry in the same cycle wins, so no restart without a fresh write
  wire       flash_go   = wr_ctl & ~fault_evt & ~timer_done &
                          (ctrl_wr[MODE_MSB:MODE_LSB] == MODE_FLASH);
  // Safety shutdown outranks a host write in the same cycle
  wire [7:0] ctrl_d     = (fault_evt | timer_done) ? (ctrl_q & ~MODE_MASK) :
                          wr_ctl ? ctrl_wr : ctrl_q;
  wire [1:0] mode_d     = ctrl_d[MODE_MSB:MODE_LSB];

  // Fault reg: only the two flags, the rest reads zero
  assign rd_val = (ptr_q == REG_CURRENT) ? current_q :
                  (ptr_q == REG_CONTROL) ? ctrl_q :
                  (ptr_q == REG_FAULT)   ? fault_q : ZERO_BYTE;

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      current_q <= CURRENT_RESET;
      ctrl_q    <= CONTROL_RESET;
      fault_q   <= FAULT_RESET;
      unlock_q  <= 1'b0;
      boost_q   <= 1'b0;
      flash_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      boost_q <= (mode_d != MODE_SHUTDOWN);
      flash_q <= (mode_d == MODE_FLASH);
      if (wr_key) begin
        unlock_q <= (wr_data_q == UNLOCK_KEY);
      end else if (wr_stb_q) begin
        unlock_q <= 1'b0;
      end
      if (wr_cur && unlock_q) begin
        current_q <= wr_data_q;
      end
      // Set beats clear-on-read in the same cycle
      fault_q[SHORT_BIT] <= sticky_next(fault_q[SHORT_BIT], set_short, rd_fault);
      fault_q[OVP_BIT]   <= sticky_next(fault_q[OVP_BIT], set_ovp, rd_fault);
    end
  end

  // Flash duration: (timer field + 1) steps of one flash step
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || flash_go) begin
      cyc_q   <= '0;
      steps_q <= RST_IN ? BIT_ZERO : ctrl_wr[TIMER_MSB:0];
    end else if (mode == MODE_FLASH) begin
      cyc_q <= step_end ? '0 : cyc_q + 32'd1;
      if (step_end && steps_q != BIT_ZERO) begin
        steps_q <= steps_q - BIT_ONE;
      end
    end
  end

  assign BOOST_EN_OUT      = boost_q;
  assign LED_MODE_OUT      = ctrl_q[MODE_MSB:MODE_LSB];
  assign DRIVE_CURRENT_OUT = current_q;
  assign FLASH_ACTIVE_OUT  = flash_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  assist_on_a: assert property (
    wr_ctl && wr_data_q == CTRL_ASSIST && !fault_evt && !timer_done |=>
      LED_MODE_OUT == MODE_ASSIST && BOOST_EN_OUT)
    else $error("assist write did not start assist light");
  coil_readback_a: assert property (
    operating && coil_s |=> LED_MODE_OUT == MODE_SHUTDOWN && !BOOST_EN_OUT)
    else $error("broken coil left driver running");
  power_off_a: assert property (
    wr_ctl && wr_data_q == CTRL_OFF |=>
      !BOOST_EN_OUT && !FLASH_ACTIVE_OUT && LED_MODE_OUT == MODE_SHUTDOWN)
    else $error("power off write left output on");
  clean_fault_a: assert property (
    fault_q == FAULT_RESET && !short_s && !ovp_s |=> fault_q == FAULT_RESET)
    else $error("fault flag set without cause");
  short_flag_a: assert property (
    operating && short_s |=> fault_q[SHORT_BIT])
    else $error("shorted LED not flagged");
  ovp_flag_a: assert property (
    operating && ovp_s |=> fault_q[OVP_BIT])
    else $error("overvoltage not flagged");
  locked_write_a: assert property (
    wr_cur && !unlock_q |=> $stable(DRIVE_CURRENT_OUT))
    else $error("locked current write took effect");
  full_current_a: assert property (
    wr_cur && unlock_q && wr_data_q == CURRENT_MAX |=> DRIVE_CURRENT_OUT == CURRENT_MAX)
    else $error("unlocked full current write lost");
  flash_start_a: assert property (
    flash_go |=> FLASH_ACTIVE_OUT && steps_q == $past(wr_data_q[TIMER_MSB:0]))
    else $error("flash did not start with its duration");
  auto_off_a: assert property (
    timer_done |=> !FLASH_ACTIVE_OUT && LED_MODE_OUT == MODE_SHUTDOWN)
    else $error("flash did not end at timer expiry");
  fault_off_a: assert property (
    fault_evt |=> !BOOST_EN_OUT && LED_MODE_OUT == MODE_SHUTDOWN)
    else $error("fault did not switch the driver off");
  relock_a: assert property (
    wr_stb_q && ptr_q != REG_UNLOCK |=> !unlock_q)
    else $error("unlock survived a following write");
  shutdown_hold_a: assert property (
    LED_MODE_OUT == MODE_SHUTDOWN && !wr_ctl |=> LED_MODE_OUT == MODE_SHUTDOWN)
    else $error("driver left shutdown without a host write");
  flag_read_a: assert property (
    rd_fault && !set_short && !set_ovp |=> fault_q == FAULT_RESET)
    else $error("fault flags survived their read");
  flash_boost_a: assert property (
    FLASH_ACTIVE_OUT |-> BOOST_EN_OUT && LED_MODE_OUT == MODE_FLASH)
    else $error("flash active without boost or flash mode");

  // ==========================================================
  // Checker-side flash length, kept apart from the duration counter
  logic [31:0] flash_len_q;
  logic [3:0]  flash_field_q;

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || flash_go) begin
      flash_len_q   <= '0;
      flash_field_q <= RST_IN ? BIT_ZERO : ctrl_wr[TIMER_MSB:0];
    end else if (FLASH_ACTIVE_OUT) begin
      flash_len_q <= flash_len_q + 32'd1;
    end
  end

  // Only a pulse that ran out by itself is measured
  flash_len_a: assert property (
    $fell(FLASH_ACTIVE_OUT) && !$past(fault_evt) && !$past(wr_ctl) |->
      flash_len_q == 32'(FLASH_STEP_CYCLES) * (32'(flash_field_q) + 32'd1))
    else $error("flash length differs from its timer field");

  assist_run_c: cover property (wr_ctl && wr_data_q == CTRL_ASSIST ##1 BOOST_EN_OUT);
  flash_done_c: cover property (timer_done);
  fault_trip_c: cover property (fault_evt);
  unlock_use_c: cover property (wr_cur && unlock_q);
  locked_drop_c: cover property (wr_cur && !unlock_q);

endmodule // flash_ctrl
`default_nettype wire

// [design/README_unused.sv]
`default_nettype none
`default_nettype wire

// [verif/bus_host_model.sv]
`default_nettype none
module bus_host_model
  import flash_ctrl_pkg::*;
#(
  parameter int HALF_NS = 100
) (
  // Bus pins
  output var  logic scl_out,
  output var  logic sda_low_out,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // ==========================================================
  // Bit level
  // SDA only moves mid-low so no data bit looks like START or STOP
  task automatic bit_io(input logic b, output logic seen);
    scl_out = 1'b0;
    #(HALF_NS / 2) sda_low_out = !b;
    #(HALF_NS / 2) scl_out = 1'b1;
    seen = sda_in;
    #(HALF_NS);
  endtask

  task automatic start_cond();
    scl_out = 1'b0;
    #(HALF_NS / 2) sda_low_out = 1'b0;
    #(HALF_NS / 2) scl_out = 1'b1;
    #(HALF_NS) sda_low_out = 1'b1;
    #(HALF_NS);
  endtask

  task automatic stop_cond();
    scl_out = 1'b0;
    #(HALF_NS / 2) sda_low_out = 1'b1;
    #(HALF_NS / 2) scl_out = 1'b1;
    #(HALF_NS) sda_low_out = 1'b0;
    #(HALF_NS);
  endtask

  // ==========================================================
  // Byte and register level
  // Ninth bit m9: 1 releases the line, 0 would be a host acknowledge
  task automatic xfer(input logic [7:0] tx, input logic m9, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(m9, s);
    ack = !s;
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] rg,
                           input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, r, ok);
    xfer(rg, 1'b1, r, a);
    xfer(d, 1'b1, r, a);
    stop_cond();
  endtask

  // Read ends with a host NACK so the device lets go of the line
  task automatic read_reg(input logic [7:0] rg, output logic [7:0] d);
    logic [7:0] r;
    logic       a;
    start_cond();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, a);
    xfer(rg, 1'b1, r, a);
    start_cond();
    xfer({DEV_ADDR, 1'b1}, 1'b1, r, a);
    xfer(8'hff, 1'b1, d, a);
    stop_cond();
  endtask
endmodule  // bus_host_model
`default_nettype wire

// [verif/tb_flash_led_control_selftest.sv]
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_flash_led_control_selftest
  import flash_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int STEP = 20;
  typedef struct packed {
    logic [7:0] rg;
    logic [7:0] wd;
    logic [7:0] rexp;
    logic [1:0] mode;
  } row_s;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       short_in = 1'b0;
  logic       ovp_in = 1'b0;
  logic       coil_in = 1'b0;
  wire        scl;
  wire        host_low;
  wire        sda_oe;
  wire        boost;
  wire        flash;
  wire  [1:0] mode;
  wire  [7:0] cur;
  wire        sda_drv;
  // Device drives the line only while enabled; pull-up otherwise
  wire        sda_line = !host_low && (sda_oe ? sda_drv : 1'b1);
  int         n_errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         flash_cycles = 0;
  logic [7:0] rd;
  logic       ok;
  row_s       rows [5] = '{
    '{REG_CONTROL, CTRL_ASSIST, CTRL_ASSIST, MODE_ASSIST},
    '{REG_CONTROL, CTRL_OFF, CTRL_OFF, MODE_SHUTDOWN},
    '{REG_FAULT, 8'hff, FAULT_RESET, MODE_SHUTDOWN},
    '{REG_UNLOCK, 8'h55, ZERO_BYTE, MODE_SHUTDOWN},
    '{8'h07, 8'h5a, ZERO_BYTE, MODE_SHUTDOWN}};

  always #2.5 clk = ~clk;

  bus_host_model host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda_line));

  flash_ctrl #(.FLASH_STEP_CYCLES(STEP)) dut (
    .CLOCK_IN(clk), .RST_IN(rst), .SCL_LINK_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_drv),
    .SDA_OE_OUT(sda_oe), .LED_SHORT_IN(short_in), .OVERVOLT_IN(ovp_in),
    .COIL_BROKEN_IN(coil_in), .BOOST_EN_OUT(boost), .LED_MODE_OUT(mode),
    .DRIVE_CURRENT_OUT(cur), .FLASH_ACTIVE_OUT(flash));

  // ==========================================================
  // Run control
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole sequence needs roughly 36000 cycles
  always @(posedge clk) begin
    cyc++;
    if (flash === 1'b1) flash_cycles++;
    if (cyc == 60000) begin
      n_errors++;
      complete_run();
    end
  end

  // ==========================================================
  // Sequence
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("cur_reset", CURRENT_RESET, cur)
    `CHK("mode_reset", MODE_SHUTDOWN, mode)
    host.read_reg(REG_CONTROL, rd);
    `CHK("ctrl_reset", CONTROL_RESET, rd)
    foreach (rows[i]) begin
      host.write_reg(DEV_ADDR, rows[i].rg, rows[i].wd, ok);
      host.read_reg(rows[i].rg, rd);
      `CHK("row_read", rows[i].rexp, rd)
      `CHK("row_mode", rows[i].mode, mode)
      `CHK("row_boost", rows[i].mode != MODE_SHUTDOWN, boost)
    end
    host.write_reg(DEV_ADDR ^ 7'h01, REG_CONTROL, CTRL_ASSIST, ok);
    `CHK("wrong_addr", 1'b0, ok)
    `CHK("wrong_addr_mode", MODE_SHUTDOWN, mode)
    host.write_reg(DEV_ADDR, REG_CURRENT, CURRENT_MAX, ok);
    `CHK("locked", CURRENT_RESET, cur)
    host.write_reg(DEV_ADDR, REG_UNLOCK, UNLOCK_KEY, ok);
    host.write_reg(DEV_ADDR, REG_CURRENT, CURRENT_MAX, ok);
    `CHK("unlocked", CURRENT_MAX, cur)
    host.write_reg(DEV_ADDR, REG_CURRENT, 8'h11, ok);
    host.read_reg(REG_CURRENT, rd);
    `CHK("relocked", CURRENT_MAX, rd)
    flash_cycles = 0;
    host.write_reg(DEV_ADDR, REG_CONTROL, 8'h3f, ok);
    `CHK("flash_mode", MODE_FLASH, mode)
    `CHK("flash_on", 1'b1, flash)
    for (int k = 0; k < 800 && flash !== 1'b0; k++) @(negedge clk);
    `CHK("flash_len", 1'b1, flash_cycles inside {[16 * STEP : 16 * STEP + 1]})
    `CHK("flash_end_mode", MODE_SHUTDOWN, mode)
    `CHK("flash_end_boost", 1'b0, boost)
    // Short then overvoltage, each while assist light runs
    for (int k = 0; k < 2; k++) begin
      host.write_reg(DEV_ADDR, REG_CONTROL, CTRL_ASSIST, ok);
      short_in = (k == 0);
      ovp_in = (k == 1);
      repeat (4) @(negedge clk);
      short_in = 1'b0;
      ovp_in = 1'b0;
      repeat (4) @(negedge clk);
      `CHK("fault_mode", MODE_SHUTDOWN, mode)
      `CHK("fault_boost", 1'b0, boost)
      host.read_reg(REG_FAULT, rd);
      `CHK("fault_flag", (k == 0) ? 8'h40 : 8'h80, rd)
    end
    host.write_reg(DEV_ADDR, REG_CONTROL, CTRL_ASSIST, ok);
    coil_in = 1'b1;
    repeat (4) @(negedge clk);
    coil_in = 1'b0;
    repeat (4) @(negedge clk);
    host.read_reg(REG_CONTROL, rd);
    `CHK("coil_read", CTRL_ASSIST & ~MODE_MASK, rd)
    `CHK("coil_boost", 1'b0, boost)
    // Mid-run reset while the current register holds a written value
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("cur_rereset", CURRENT_RESET, cur)
    `CHK("boost_rereset", 1'b0, boost)
    host.read_reg(REG_CONTROL, rd);
    `CHK("ctrl_rereset", CONTROL_RESET, rd)
    host.write_reg(DEV_ADDR, REG_CURRENT, CURRENT_MAX, ok);
    `CHK("reset_locked", CURRENT_RESET, cur)
    complete_run();
  end
endmodule  // tb_flash_led_control_selftest
`default_nettype wire
